// [design/link_consts.svh]
// Notes on behaviour
// - telegram carries 16 slots, 16-bit each
// - unmapped send slots go out as zero
// - one telegram sent per transfer cycle
// - accept all telegrams, pick up to 16
// - 32-bit values use two adjacent slots
// - duplicate mapping raises configuration alarm
// - reading own node raises distinct alarm
// - current cycle 250 or 500, else alarm
// - bus cycle multiple of controller cycles
// - sync mode node limit 16 or 64
// - free mode paced by sampling, 64 nodes
// - limit and sync settings latched at power-on
// - node 1 is sync master
// - node number 0 disables the link
// - per-slot source node, 0 captures nothing
// - per-slot word select, 0 selects none
// - send map places values into slots
// - first word bit 10 checked unless mode 2
// - signal routing changeable at run time
// - latency target 1000 us at 500 us bus
// - missing sender alarm carries node, self-clears
// - failure in cyclic run adds timeout fault
`ifndef LINK_CONSTS_SVH
`define LINK_CONSTS_SVH
`define SLOT_COUNT        16
`define CTRL_CHECK_BIT    10
`define CHECK_OFF_MODE    2'h2
`define CYC_250_US        16'h00FA
`define CYC_500_US        16'h01F4
`define CYC_400_ALARM     8'h04
`define NODES_SMALL       7'h10
`define NODES_LARGE       7'h40
`define BUS_500_US        16'h01F4
`define CLK_MHZ           200
`define CYCLES_PER_US     (`CLK_MHZ)
`define MISS_CYCLES_MAX   4'h3
`endif

// [design/link_pkg.sv]
package link_pkg;
   // one word arriving on the link with its sender and slot index
   typedef struct packed {
      logic [6:0]  node;
      logic [3:0]  index;
      logic [15:0] data;
   } link_word_t;
   // latched power-on configuration
   typedef struct packed {
      logic        sync_mode;
      logic [6:0]  max_nodes;
      logic [6:0]  node_number;
   } boot_cfg_t;
endpackage : link_pkg

// [design/process_data_link.sv]
`timescale 1ns/1ps
`default_nettype none
`include "link_consts.svh"
// =====================================================
// node logic: send telegram, receive selection, alarms
module process_data_link
   import link_pkg::*;
(
   input  wire logic          ref_clk_i,
   input  wire logic          rst_i,
   // configuration; node number, node limit and sync mode latched at reset release, the rest used live
   input  wire logic [6:0]    node_number_i,
   input  wire logic [6:0]    max_node_count_i,
   input  wire logic          sync_mode_select_i,
   input  wire logic [15:0]   bus_cycle_setting_i,
   input  wire logic [15:0]   current_loop_cycle_i,
   input  wire logic [15:0]   speed_loop_cycle_i,
   input  wire logic [15:0]   master_cycle_time_i,
   input  wire logic [1:0]    ctrl_bit_check_mode_i,
   // run-time mapping
   input  wire logic [255:0]  send_word_source_i,   // 16 words of internal signals
   input  wire logic [79:0]   send_slot_map_i,      // 5 bits/slot: 0 none, else source 1..16
   input  wire logic [111:0]  receive_source_node_i,// 7 bits/slot
   input  wire logic [79:0]   receive_word_select_i,// 5 bits/slot: 0 none, else word 1..16
   // cycle strobe (bus cycle or sampling time), asynchronous source
   input  wire logic          cycle_tick_i,
   // link receive stream
   input  wire logic          rx_valid_i,
   output logic               rx_ready_o,
   input  wire link_word_t    rx_word_i,
   // link transmit stream
   output logic               tx_valid_o,
   input  wire logic          tx_ready_i,
   output logic [15:0]        tx_data_o,
   output logic [3:0]         tx_index_o,
   // results
   output logic [255:0]       received_word_o,
   output logic               link_enabled_o,
   output logic               sync_master_o,
   output logic               duplicate_word_alarm_a_o,
   output logic               duplicate_word_alarm_b_o,
   output logic               own_data_read_alarm_o,
   output logic               cycle_config_alarm_o,
   output logic [7:0]         cycle_config_value_o,
   output logic               missing_sender_alarm_o,
   output logic [6:0]         missing_sender_node_o,
   output logic               setpoint_timeout_fault_o,
   output logic               ctrl_bit_fault_o
);
   // =====================================================
   // boot configuration capture
   boot_cfg_t cfg_r;          // latched settings
   logic      cfg_done_r;     // capture happened
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_r      <= '0;
         cfg_done_r <= 1'b0;
      end else if (!cfg_done_r) begin
         cfg_r.node_number <= node_number_i;
         cfg_r.sync_mode   <= sync_mode_select_i;
         // limit follows bus cycle in sync mode
         if (sync_mode_select_i && bus_cycle_setting_i == `BUS_500_US) begin
            cfg_r.max_nodes <= (max_node_count_i > `NODES_SMALL) ? `NODES_SMALL : max_node_count_i;
         end else begin
            cfg_r.max_nodes <= (max_node_count_i > `NODES_LARGE) ? `NODES_LARGE : max_node_count_i;
         end
         cfg_done_r <= 1'b1;
      end
   end
   logic enabled;
   assign enabled = cfg_done_r && (cfg_r.node_number != 7'h00);

   // =====================================================
   // cycle strobe synchroniser and edge detect
   logic [2:0] tick_r;
   logic       tick;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) tick_r <= 3'h0;
      else       tick_r <= {tick_r[1:0], cycle_tick_i};
   end
   assign tick = tick_r[1] & ~tick_r[2];

   // =====================================================
   // cycle configuration checks
   logic cyc_bad, mult_bad;
   assign cyc_bad  = (current_loop_cycle_i != `CYC_250_US) && (current_loop_cycle_i != `CYC_500_US);
   assign mult_bad = (current_loop_cycle_i == 16'h0000) || (speed_loop_cycle_i == 16'h0000) ||
                     (cfg_r.sync_mode && (bus_cycle_setting_i % current_loop_cycle_i) != 16'h0000) ||
                     ((master_cycle_time_i % speed_loop_cycle_i) != 16'h0000);
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cycle_config_alarm_o <= 1'b0;
         cycle_config_value_o <= 8'h00;
      end else begin
         cycle_config_alarm_o <= enabled && (cyc_bad || mult_bad);
         cycle_config_value_o <= cyc_bad ? `CYC_400_ALARM : 8'h00;
      end
   end

   // =====================================================
   // mapping checks: duplicates and own-node read
   logic dup_tx, dup_rx, own_rd;
   always_comb begin
      dup_tx = 1'b0;
      dup_rx = 1'b0;
      own_rd = 1'b0;
      for (int i = 0; i < `SLOT_COUNT; i++) begin
         if (receive_source_node_i[i*7 +: 7] == cfg_r.node_number && cfg_r.node_number != 7'h00)
            own_rd = 1'b1;
         for (int j = i + 1; j < `SLOT_COUNT; j++) begin
            if (send_slot_map_i[i*5 +: 5] != 5'h00 && send_slot_map_i[i*5 +: 5] == send_slot_map_i[j*5 +: 5])
               dup_tx = 1'b1;
            if (receive_word_select_i[i*5 +: 5] != 5'h00 &&
                receive_word_select_i[i*5 +: 5] == receive_word_select_i[j*5 +: 5] &&
                receive_source_node_i[i*7 +: 7] == receive_source_node_i[j*7 +: 7])
               dup_rx = 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         duplicate_word_alarm_a_o <= 1'b0;
         duplicate_word_alarm_b_o <= 1'b0;
         own_data_read_alarm_o    <= 1'b0;
         link_enabled_o           <= 1'b0;
         sync_master_o            <= 1'b0;
      end else begin
         duplicate_word_alarm_a_o <= enabled && dup_tx;
         duplicate_word_alarm_b_o <= enabled && dup_rx;
         own_data_read_alarm_o    <= enabled && own_rd;
         link_enabled_o           <= enabled;
         sync_master_o            <= enabled && cfg_r.node_number == 7'h01;
      end
   end

   // =====================================================
   // transmit: one 16-slot telegram per cycle
   logic       tx_busy_r;
   logic [3:0] tx_cnt_r;
   logic [15:0] slot_val;
   logic [4:0]  map_sel;
   always_comb begin
      map_sel  = send_slot_map_i[tx_cnt_r*5 +: 5];
      slot_val = (map_sel == 5'h00) ? 16'h0000 : send_word_source_i[(map_sel - 5'h01)*16 +: 16];
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_busy_r  <= 1'b0;
         tx_cnt_r   <= 4'h0;
         tx_valid_o <= 1'b0;
         tx_data_o  <= 16'h0000;
         tx_index_o <= 4'h0;
      end else if (tx_valid_o && !tx_ready_i) begin
         // hold word until taken
      end else if (tx_busy_r) begin
         tx_valid_o <= 1'b1;
         tx_data_o  <= slot_val;
         tx_index_o <= tx_cnt_r;
         tx_cnt_r   <= tx_cnt_r + 4'h1;
         if (tx_cnt_r == 4'hF) tx_busy_r <= 1'b0;
      end else begin
         tx_valid_o <= 1'b0;
         if (tick && enabled) begin
            tx_busy_r <= 1'b1;
            tx_cnt_r  <= 4'h0;
         end
      end
   end

   // =====================================================
   // receive buffer
   link_word_t f_word;
   logic       f_valid;
   word_fifo #(.WIDTH(27), .DEPTH(8)) u_rx_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (rx_valid_i),
      .in_ready_o  (rx_ready_o),
      .in_data_i   (rx_word_i),
      .out_valid_o (f_valid),
      .out_ready_i (1'b1),
      .out_data_o  (f_word)
   );

   // =====================================================
   // receive selection: stage per slot, commit at cycle tick
   logic [255:0] stage_r;
   logic [63:0]  heard_r;     // senders heard this cycle
   genvar g;
   generate
      for (g = 0; g < `SLOT_COUNT; g++) begin : g_slot
         wire [6:0] src = receive_source_node_i[g*7 +: 7];
         wire [4:0] sel = receive_word_select_i[g*5 +: 5];
         // capture only valid, non-own selections
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               stage_r[g*16 +: 16] <= 16'h0000;
            end else if (f_valid && enabled && src != 7'h00 && sel != 5'h00 &&
                         src != cfg_r.node_number && f_word.node == src &&
                         {1'b0, f_word.index} == sel - 5'h01) begin
               stage_r[g*16 +: 16] <= f_word.data;
            end
         end
         // commit all slots together
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) received_word_o[g*16 +: 16] <= 16'h0000;
            else if (tick && enabled) received_word_o[g*16 +: 16] <= stage_r[g*16 +: 16];
         end
      end
   endgenerate
   // =====================================================
   // sender presence tracking and alarms
   logic [63:0] miss_now;
   logic [3:0]  cycles_r;
   logic        running_r;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         heard_r <= 64'h0;
      end else if (tick) begin
         heard_r <= 64'h0;
      end else if (f_valid && f_word.node != 7'h00 && f_word.node <= 7'd64) begin
         heard_r[f_word.node[5:0] - 6'h01] <= 1'b1;
      end
   end
   always_comb begin
      miss_now = 64'h0;
      for (int n = 1; n <= 64; n++) begin
         if (n <= cfg_r.max_nodes && n != cfg_r.node_number) miss_now[n-1] = ~heard_r[n-1];
      end
   end
   logic [6:0] first_miss;
   always_comb begin
      first_miss = 7'h00;
      for (int n = 64; n >= 1; n--) begin
         if (miss_now[n-1]) first_miss = 7'(n);
      end
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cycles_r                 <= 4'h0;
         running_r                <= 1'b0;
         missing_sender_alarm_o   <= 1'b0;
         missing_sender_node_o    <= 7'h00;
         setpoint_timeout_fault_o <= 1'b0;
      end else if (tick && enabled) begin
         if (cycles_r != `MISS_CYCLES_MAX) cycles_r <= cycles_r + 4'h1;
         missing_sender_alarm_o <= (cycles_r == `MISS_CYCLES_MAX) && (first_miss != 7'h00);
         missing_sender_node_o  <= first_miss;
         if (first_miss == 7'h00 && cycles_r == `MISS_CYCLES_MAX) running_r <= 1'b1;
         setpoint_timeout_fault_o <= running_r && (first_miss != 7'h00);
      end
   end

   // =====================================================
   // control word bit check on first received slot
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) ctrl_bit_fault_o <= 1'b0;
      else if (tick && enabled)
         ctrl_bit_fault_o <= (ctrl_bit_check_mode_i != `CHECK_OFF_MODE) && !stage_r[`CTRL_CHECK_BIT];
   end

   // =====================================================
   // assertions
   property p_disabled_quiet;
      @(posedge ref_clk_i) disable iff (rst_i) !enabled |=> !tx_valid_o;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("tx while disabled");
   property p_master;
      @(posedge ref_clk_i) disable iff (rst_i) sync_master_o |-> cfg_r.node_number == 7'h01;
   endproperty
   a_master: assert property (p_master) else $error("wrong sync master");
   property p_bad_cycle;
      @(posedge ref_clk_i) disable iff (rst_i) (enabled && cyc_bad) |=> cycle_config_value_o == 8'h04;
   endproperty
   a_bad_cycle: assert property (p_bad_cycle) else $error("cycle alarm value wrong");
   property p_own;
      @(posedge ref_clk_i) disable iff (rst_i) (enabled && own_rd) |=> own_data_read_alarm_o;
   endproperty
   a_own: assert property (p_own) else $error("own read not flagged");
   property p_cfg_hold;
      @(posedge ref_clk_i) disable iff (rst_i) cfg_done_r |=> $stable(cfg_r);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed at run time");
   sequence s_start; tick && enabled && !tx_busy_r && !(tx_valid_o && !tx_ready_i); endsequence
   property p_telegram;
      @(posedge ref_clk_i) disable iff (rst_i) s_start |=> tx_busy_r && tx_cnt_r == 4'h0;
   endproperty
   a_telegram: assert property (p_telegram) else $error("telegram not started");
   property p_limit;
      @(posedge ref_clk_i) disable iff (rst_i) cfg_done_r |-> cfg_r.max_nodes <= 7'h40;
   endproperty
   a_limit: assert property (p_limit) else $error("node limit too high");
   property p_commit;
      @(posedge ref_clk_i) disable iff (rst_i) !(tick && enabled) |=> $stable(received_word_o);
   endproperty
   a_commit: assert property (p_commit) else $error("receive slots changed mid cycle");
endmodule : process_data_link
`default_nettype wire

// [design/word_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// small synchronous fifo
module word_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];   // storage
   logic [AW-1:0]    wp_r, rp_r;    // pointers
   logic [AW:0]      cnt_r;         // fill level
   logic             wr, rd;
   assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));   // refuse only when every entry is held
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o  = mem[rp_r];
   assign wr = in_valid_i & in_ready_o;
   assign rd = out_valid_o & out_ready_i;
   // storage write
   always_ff @(posedge ref_clk_i) begin
      if (wr) begin
         mem[wp_r] <= in_data_i;
      end
   end
   // pointers and level
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (wr) wp_r <= wp_r + AW'(1);
         if (rd) rp_r <= rp_r + AW'(1);
         cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
      end
   end
endmodule : word_fifo
`default_nettype wire

// [testbench/peer_node.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================
// peer node: broadcasts whole telegrams into the receive stream
// one upstream neighbour on a line, no switch ports in use
module peer_node
   import link_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic rx_ready_i,
   output logic      rx_valid_o,
   output link_word_t rx_word_o
);
   initial begin
      rx_valid_o = 1'b0;
      rx_word_o  = '0;
   end
   // one telegram of 16 words, indices 0..15; slow leaves gaps
   task automatic send(input logic [6:0] node, input logic [255:0] words, input bit slow);
      int k;
      int n;
      @(negedge ref_clk_i);
      for (k = 0; k < 16; k++) begin
         rx_valid_o = 1'b1;
         rx_word_o  = '{node: node, index: 4'(k), data: words[k*16 +: 16]};
         n = 0;
         // ready only moves after a rising edge, so the falling edge sees it settled
         while (!rx_ready_i && n < 100) begin
            @(negedge ref_clk_i);
            n++;
         end
         @(posedge ref_clk_i);
         @(negedge ref_clk_i);
         if (slow || k == 15) begin
            rx_valid_o = 1'b0;
            rx_word_o  = link_word_t'(~rx_word_o); // released: no stale word
         end
         if (slow) repeat (2) @(negedge ref_clk_i);
      end
   endtask : send
endmodule : peer_node
`default_nettype wire

// [testbench/process_data_link_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================
// bench: peer on rx, queue-checked tx, alarms as levels
module process_data_link_tb;
   import link_pkg::*;
   logic ref_clk_i, rst_i, cycle_tick_i, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
   logic [6:0]   node_number_i, max_node_count_i, missing_sender_node_o;
   logic         sync_mode_select_i, link_enabled_o, sync_master_o, own_data_read_alarm_o;
   logic [15:0]  bus_cycle_setting_i, current_loop_cycle_i, speed_loop_cycle_i, master_cycle_time_i, tx_data_o;
   logic [1:0]   ctrl_bit_check_mode_i;
   logic [255:0] send_word_source_i, received_word_o, t1, t3, rx_exp;
   logic [79:0]  send_slot_map_i, receive_word_select_i;
   logic [111:0] receive_source_node_i;
   logic [3:0]   tx_index_o;
   logic [7:0]   cycle_config_value_o;
   logic         duplicate_word_alarm_a_o, duplicate_word_alarm_b_o, cycle_config_alarm_o;
   logic         missing_sender_alarm_o, setpoint_timeout_fault_o, ctrl_bit_fault_o;
   link_word_t   rx_word_i;
   logic [19:0]  exp_q[$];    // expected {index, data} of transmitted words
   logic [15:0]  lf, rdy_lf;  // random sources
   int           n_fail, total_checks, s;

   process_data_link dut (.ref_clk_i, .rst_i, .node_number_i, .max_node_count_i, .sync_mode_select_i,
      .bus_cycle_setting_i, .current_loop_cycle_i, .speed_loop_cycle_i, .master_cycle_time_i,
      .ctrl_bit_check_mode_i, .send_word_source_i, .send_slot_map_i, .receive_source_node_i,
      .receive_word_select_i, .cycle_tick_i, .rx_valid_i, .rx_ready_o, .rx_word_i, .tx_valid_o,
      .tx_ready_i, .tx_data_o, .tx_index_o, .received_word_o, .link_enabled_o, .sync_master_o,
      .duplicate_word_alarm_a_o, .duplicate_word_alarm_b_o, .own_data_read_alarm_o,
      .cycle_config_alarm_o, .cycle_config_value_o, .missing_sender_alarm_o, .missing_sender_node_o,
      .setpoint_timeout_fault_o, .ctrl_bit_fault_o);
   peer_node peer (.ref_clk_i, .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i), .rx_word_o(rx_word_i));

   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr

   function automatic logic [255:0] rnd256();
      logic [255:0] v;
      for (int k = 0; k < 16; k++) begin
         lf = lfsr(lf);
         v[k*16 +: 16] = lf;
      end
      return v;
   endfunction : rnd256

   // expected content of own send slot
   function automatic logic [15:0] slot_val(input int k);
      int m;
      m = int'(send_slot_map_i[k*5 +: 5]);
      return (m == 0) ? 16'h0000 : send_word_source_i[(m-1)*16 +: 16];
   endfunction : slot_val

   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // =====================================
   // tx monitor: stalls ready at random, takes the oldest note per word
   always @(negedge ref_clk_i) begin
      rdy_lf = lfsr(rdy_lf);
      if (tx_valid_o && rdy_lf[0]) begin
         if (exp_q.size() == 0) check(1, 0);
         else check({tx_index_o, tx_data_o}, exp_q.pop_front());
      end
      tx_ready_i = rdy_lf[0];
   end

   // one transfer cycle; en notes the telegram that must follow
   task automatic tick(input bit en);
      int n;
      if (en) for (int k = 0; k < 16; k++) exp_q.push_back({4'(k), slot_val(k)});
      @(negedge ref_clk_i) cycle_tick_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      cycle_tick_i = 1'b0;
      n = 0;
      while ((exp_q.size() != 0 || tx_valid_o) && n < 300) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (n == 300) begin
         n_fail++;
         test_done();
      end
      repeat (4) @(negedge ref_clk_i);
   endtask : tick

   task automatic do_reset(input logic [6:0] node);
      node_number_i = node;
      rst_i = 1'b1;
      rx_exp = '0;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
   endtask : do_reset

   // peers send, nothing moves before the tick, all slots move at it
   task automatic round(input bit with3, input bit bit10);
      int sel;
      t1 = rnd256();
      t1[10] = bit10;
      t3 = rnd256();
      peer.send(7'h01, t1, 1'b0);
      if (with3) peer.send(7'h03, t3, 1'b1);
      check(received_word_o, rx_exp);
      for (int k = 0; k < 16; k++) begin
         sel = int'(receive_word_select_i[k*5 +: 5]);
         if (sel != 0 && receive_source_node_i[k*7 +: 7] == 7'h01) rx_exp[k*16 +: 16] = t1[(sel-1)*16 +: 16];
         if (with3 && sel != 0 && receive_source_node_i[k*7 +: 7] == 7'h03)
            rx_exp[k*16 +: 16] = t3[(sel-1)*16 +: 16];
      end
      send_word_source_i = rnd256();
      tick(1);
      check(received_word_o, rx_exp);
   endtask : round

   // =====================================
   // main sequence
   initial begin
      n_fail = 0;
      total_checks = 0;
      lf = 16'h0029;
      rdy_lf = 16'h0029;
      rst_i = 1'b1;
      cycle_tick_i = 1'b0;
      tx_ready_i = 1'b0;
      node_number_i = 7'h02;
      max_node_count_i = 7'h03;
      sync_mode_select_i = 1'b1;
      bus_cycle_setting_i = 16'h01F4;
      current_loop_cycle_i = 16'h00FA;
      speed_loop_cycle_i = 16'h00FA;
      master_cycle_time_i = 16'h01F4;
      ctrl_bit_check_mode_i = 2'h0;
      send_word_source_i = rnd256();
      for (s = 0; s < 16; s++) begin
         send_slot_map_i[s*5 +: 5] = 5'((s + 3) % 17);
         receive_source_node_i[s*7 +: 7] = (s < 8) ? 7'h01 : 7'h03;
         receive_word_select_i[s*5 +: 5] = 5'(s + 1);
      end
      receive_source_node_i[14*7 +: 7] = 7'h00;
      receive_word_select_i[15*5 +: 5] = 5'h00;
      do_reset(7'h02);
      check({link_enabled_o, sync_master_o, duplicate_word_alarm_a_o, duplicate_word_alarm_b_o}, 4'h8);
      repeat (4) tick(1);
      check({missing_sender_alarm_o, missing_sender_node_o}, 8'h81);
      $display("test startup done");
      round(1, 1);
      round(1, 1);
      check({missing_sender_alarm_o, setpoint_timeout_fault_o, ctrl_bit_fault_o}, 3'h0);
      $display("test receive done");
      repeat (4) round(0, 0);
      check({missing_sender_alarm_o, missing_sender_node_o}, 8'h83);
      check({setpoint_timeout_fault_o, ctrl_bit_fault_o}, 2'h3);
      ctrl_bit_check_mode_i = 2'h2;
      round(0, 0);
      check(ctrl_bit_fault_o, 0);
      $display("test failure done");
      send_slot_map_i[5 +: 5] = send_slot_map_i[4:0];
      tick(1);
      check(duplicate_word_alarm_a_o, 1);
      send_slot_map_i[5 +: 5] = 5'h04;
      receive_source_node_i[13:7] = receive_source_node_i[6:0];
      receive_word_select_i[9:5] = receive_word_select_i[4:0];
      tick(1);
      check({duplicate_word_alarm_a_o, duplicate_word_alarm_b_o}, 2'h1);
      receive_word_select_i[9:5] = 5'h02;
      receive_source_node_i[5*7 +: 7] = 7'h02;
      tick(1);
      check({duplicate_word_alarm_b_o, own_data_read_alarm_o}, 2'h1);
      receive_source_node_i[5*7 +: 7] = 7'h01;
      current_loop_cycle_i = 16'h0190;
      tick(1);
      check({own_data_read_alarm_o, cycle_config_alarm_o, cycle_config_value_o}, 10'h104);
      current_loop_cycle_i = 16'h01F4;
      tick(1);
      check(cycle_config_alarm_o, 0);
      $display("test alarms done");
      node_number_i = 7'h01;
      sync_mode_select_i = 1'b0;
      tick(1);
      check({link_enabled_o, sync_master_o}, 2'h2);
      do_reset(7'h01);
      check({link_enabled_o, sync_master_o}, 2'h3);
      tick(1);
      do_reset(7'h00);
      check({link_enabled_o, sync_master_o}, 2'h0);
      tick(0);
      $display("test node number done");
      test_done();
   end
endmodule : process_data_link_tb
`default_nettype wire
